/* File: verilog/io_control_config_bytes.sv */
// Purpose: Configuration bank of an I/O controller written by the host each exchange.
// Assumes: exchange_i is a one-cycle pulse on clk_i per completed exchange.
// Notes:   Pins and digital inputs arrive unsynchronised and pass two flip-flops.
//
// Implementation choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "io_cfg_map.svh"
module io_control_config_bytes #(
	parameter int DIN_N         = 16,
	parameter int PIN_N         = 4,
	parameter int PERSIST_N     = 64,
	parameter int LAMP_HALF_CYC = `LAMP_HALF_MS * `CLK_KHZ
) (
	// Clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  resetn_i,
	// Register bus
	input  wire io_cfg_pkg::wb_req_t   wb_req_i,
	output io_cfg_pkg::wb_rsp_t        wb_rsp_o,
	// Exchange timing
	input  wire logic                  exchange_i,
	// Digital inputs and outputs
	input  wire logic [DIN_N-1:0]      din_i,
	output logic      [7:0]            dout_o,
	output logic      [3:0]            relay_o,
	output logic                       pwm_hiz_o,
	// General-purpose pins
	input  wire logic [PIN_N-1:0]      pin_i,
	output logic      [PIN_N-1:0]      pin_o,
	output logic      [PIN_N-1:0]      pin_oe_o,
	output logic      [PIN_N-1:0]      pin_pullup_o,
	output logic      [PIN_N-1:0]      probe_mode_o,
	input  wire io_cfg_pkg::probe_word_t probe_i [PIN_N],
	// Persistence and lamp
	output logic                       persist_store_o,
	output logic                       status_lamp_o
);

	generate
		if (DIN_N != 16 || PIN_N != 4 || PERSIST_N != 64 || LAMP_HALF_CYC < 1) begin : g_bad_param
			$error("io_control_config_bytes supports 16 inputs, 4 pins, 64 bytes");
		end
	endgenerate

	// ---------------------------------------------------------------
	// Bus decode
	// ---------------------------------------------------------------
	io_cfg_pkg::mode_t mode_ff;
	logic              ack_ff;
	logic [31:0]       rdat_ff;
	logic [31:0]       nxt_rdat;
	logic              take;
	logic              wr;
	logic [7:0]        wbyte;
	logic [9:0]        adr;
	logic [5:0]        idx;

	assign adr   = wb_req_i.adr;
	assign idx   = adr[7:2];
	assign wbyte = wb_req_i.dat[7:0];
	assign take  = wb_req_i.cyc & wb_req_i.stb & ~ack_ff;
	// Once halted, host writes are answered but change nothing.
	assign wr    = take & wb_req_i.we & wb_req_i.sel[0] & (mode_ff == io_cfg_pkg::ST_RUN);

	// ---------------------------------------------------------------
	// Configuration registers
	// ---------------------------------------------------------------
	logic [7:0] ctrl_ff;
	logic [7:0] in_filt_ff [8];
	logic [7:0] pin_filt_ff [2];
	logic [7:0] pin_cfg_ff;
	logic [7:0] pin_out_ff;
	logic [7:0] dout_ff;
	logic [3:0] relay_ff;
	logic [9:0] rel_in;
	logic [9:0] rel_pf;

	assign rel_in = adr - `IN_FILT_ADR;
	assign rel_pf = adr - `PIN_FILT_ADR;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctrl_ff    <= `CFG_RST;
			pin_cfg_ff <= `CFG_RST;
			pin_out_ff <= `CFG_RST;
			dout_ff    <= `CFG_RST;
			relay_ff   <= 4'h0;
			for (int i = 0; i < 8; i++) begin
				in_filt_ff[i] <= `CFG_RST;
			end
			pin_filt_ff[0] <= `CFG_RST;
			pin_filt_ff[1] <= `CFG_RST;
		end else if (wr) begin
			if (adr == `CTRL_ADR) begin
				ctrl_ff <= wbyte & `CTRL_MASK;
			end else if (adr >= `IN_FILT_ADR && adr < `PIN_CFG_ADR && adr[1:0] == 2'h0) begin
				in_filt_ff[rel_in[4:2]] <= wbyte;
			end else if (adr == `PIN_CFG_ADR) begin
				pin_cfg_ff <= wbyte;
			end else if (adr >= `PIN_FILT_ADR && adr < `PIN_OUT_ADR && adr[1:0] == 2'h0) begin
				pin_filt_ff[rel_pf[2]] <= wbyte;
			end else if (adr == `PIN_OUT_ADR) begin
				pin_out_ff <= wbyte;
			end else if (adr == `DOUT_ADR) begin
				dout_ff <= wbyte;
			end else if (adr == `RELAY_ADR) begin
				relay_ff <= wbyte[3:0];
			end
		end
	end

	// ---------------------------------------------------------------
	// Safe state
	// ---------------------------------------------------------------
	logic halt_req;
	logic store_ff;

	assign halt_req = wr & (adr == `CTRL_ADR) & wbyte[`CTRL_HALT];

	// Only a reset leaves the safe state; no write path returns to run.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mode_ff  <= io_cfg_pkg::ST_RUN;
			store_ff <= 1'b0;
		end else begin
			store_ff <= 1'b0;
			case (mode_ff)
				io_cfg_pkg::ST_RUN: begin
					if (halt_req) begin
						mode_ff  <= io_cfg_pkg::ST_SAFE;
						store_ff <= wbyte[`CTRL_ARM];
					end
				end
				default: begin
					mode_ff <= io_cfg_pkg::ST_SAFE;
				end
			endcase
		end
	end

	logic safe;
	logic tick;

	assign safe = (mode_ff == io_cfg_pkg::ST_SAFE);
	// Exchanges stop counting once halted, so filters and the echo freeze.
	assign tick = exchange_i & ~safe;

	// ---------------------------------------------------------------
	// Persistent data
	// ---------------------------------------------------------------
	logic [7:0] pout_ff   [PERSIST_N];
	logic [7:0] sent_ff   [PERSIST_N];
	logic [7:0] echo_ff   [PERSIST_N];
	logic [7:0] stored_ff [PERSIST_N];
	logic [7:0] pin_view  [PERSIST_N];

	genvar g;
	generate
		for (g = 0; g < PERSIST_N; g++) begin : g_persist
			always_ff @(posedge clk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					pout_ff[g] <= `CFG_RST;
				end else if (wr && adr[9:8] == `POUT_REGION && idx == 6'(g)) begin
					pout_ff[g] <= wbyte;
				end
			end
			// Bytes sent with one exchange are returned with the next one, not the same one.
			always_ff @(posedge clk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					sent_ff[g] <= `CFG_RST;
					echo_ff[g] <= `CFG_RST;
				end else if (tick) begin
					sent_ff[g] <= pout_ff[g];
					echo_ff[g] <= sent_ff[g];
				end
			end
			// The echo path has its own copy, so mirroring never touches this.
			always_ff @(posedge clk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					stored_ff[g] <= `CFG_RST;
				end else if (store_ff) begin
					stored_ff[g] <= pout_ff[g];
				end
			end
			assign pin_view[g] = ctrl_ff[`CTRL_MIRROR] ? echo_ff[g] : stored_ff[g];
		end
	endgenerate

	// ---------------------------------------------------------------
	// Input synchronisers and filters
	// ---------------------------------------------------------------
	logic [DIN_N-1:0] din_s1_ff;
	logic [DIN_N-1:0] din_s2_ff;
	logic [PIN_N-1:0] pin_s1_ff;
	logic [PIN_N-1:0] pin_s2_ff;
	logic [DIN_N-1:0] din_flt;
	logic [PIN_N-1:0] pin_flt;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			din_s1_ff <= '0;
			din_s2_ff <= '0;
			pin_s1_ff <= '0;
			pin_s2_ff <= '0;
		end else begin
			din_s1_ff <= din_i;
			din_s2_ff <= din_s1_ff;
			pin_s1_ff <= pin_i;
			pin_s2_ff <= pin_s1_ff;
		end
	end

	generate
		for (g = 0; g < DIN_N; g++) begin : g_din
			level_filter #(.CNT_W(8)) u_flt (
				.clk_i    (clk_i),
				.resetn_i (resetn_i),
				.tick_i   (tick),
				.level_i  (din_s2_ff[g]),
				.count_i  (in_filt_ff[g/2]),
				.level_o  (din_flt[g])
			);
		end
		for (g = 0; g < PIN_N; g++) begin : g_pin
			level_filter #(.CNT_W(8)) u_flt (
				.clk_i    (clk_i),
				.resetn_i (resetn_i),
				.tick_i   (tick),
				.level_i  (pin_s2_ff[g]),
				.count_i  (pin_filt_ff[g/2]),
				.level_o  (pin_flt[g])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// Pins and probes
	// ---------------------------------------------------------------
	logic [3:0]  dir;
	logic [3:0]  probe;
	logic [15:0] temp_ff [PIN_N];
	logic [15:0] hum_ff  [PIN_N];
	logic [3:0]  pin_o_ff;
	logic [3:0]  pin_oe_ff;
	logic [3:0]  pullup_ff;
	logic [3:0]  probe_ff;

	assign dir   = pin_cfg_ff[`CFG_DIR_LSB +: 4];
	assign probe = pin_cfg_ff[`CFG_PROBE_LSB +: 4];

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pin_o_ff  <= 4'h0;
			pin_oe_ff <= 4'h0;
			pullup_ff <= 4'h0;
			probe_ff  <= 4'h0;
		end else begin
			pin_o_ff  <= pin_out_ff[3:0];
			pin_oe_ff <= dir & ~probe;
			pullup_ff <= {4{ctrl_ff[`CTRL_PULLUP]}} & ~dir & ~probe & pin_out_ff[3:0];
			probe_ff  <= probe;
		end
	end

	generate
		for (g = 0; g < PIN_N; g++) begin : g_probe
			always_ff @(posedge clk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					temp_ff[g] <= 16'h0000;
					hum_ff[g]  <= 16'h0000;
				end else if (tick) begin
					temp_ff[g] <= probe[g] ? probe_i[g].temp : 16'h0000;
					hum_ff[g]  <= probe[g] ? probe_i[g].hum : 16'h0000;
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// Safe outputs and status lamp
	// ---------------------------------------------------------------
	logic [7:0]  dout_q_ff;
	logic [3:0]  relay_q_ff;
	logic        hiz_ff;
	logic        lamp_ff;
	logic [31:0] div_ff;
	logic [2:0]  phase_ff;
	logic        flash;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dout_q_ff  <= 8'h00;
			relay_q_ff <= 4'h0;
			hiz_ff     <= 1'b0;
		end else begin
			dout_q_ff  <= safe ? 8'h00 : dout_ff;
			relay_q_ff <= safe ? 4'h0 : relay_ff;
			hiz_ff     <= safe;
		end
	end

	// The flash count names the cause; a host halt gives two flashes per frame.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			div_ff   <= 32'h0000_0000;
			phase_ff <= 3'h0;
		end else if (!safe) begin
			div_ff   <= 32'h0000_0000;
			phase_ff <= 3'h0;
		end else if (div_ff == 32'(LAMP_HALF_CYC - 1)) begin
			div_ff   <= 32'h0000_0000;
			phase_ff <= phase_ff + 3'h1;
		end else begin
			div_ff <= div_ff + 32'h0000_0001;
		end
	end

	assign flash = ~phase_ff[0] & ({1'b0, phase_ff[2:1]} < `HALT_FLASHES);

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			lamp_ff <= 1'b1;
		end else if (ctrl_ff[`CTRL_LAMP_OFF]) begin
			lamp_ff <= 1'b0;
		end else begin
			lamp_ff <= safe ? flash : 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// Read path
	// ---------------------------------------------------------------
	always_comb begin
		nxt_rdat = 32'h0000_0000;
		if (adr[9:8] == `POUT_REGION) begin
			nxt_rdat[7:0] = pout_ff[idx];
		end else if (adr[9:8] == `PIN_REGION) begin
			nxt_rdat[7:0] = pin_view[idx];
		end else if (adr == `CTRL_ADR) begin
			nxt_rdat[7:0] = ctrl_ff;
		end else if (adr >= `IN_FILT_ADR && adr < `PIN_CFG_ADR && adr[1:0] == 2'h0) begin
			nxt_rdat[7:0] = in_filt_ff[rel_in[4:2]];
		end else if (adr == `PIN_CFG_ADR) begin
			nxt_rdat[7:0] = pin_cfg_ff;
		end else if (adr >= `PIN_FILT_ADR && adr < `PIN_OUT_ADR && adr[1:0] == 2'h0) begin
			nxt_rdat[7:0] = pin_filt_ff[rel_pf[2]];
		end else if (adr == `PIN_OUT_ADR) begin
			nxt_rdat[7:0] = pin_out_ff;
		end else if (adr == `DOUT_ADR) begin
			nxt_rdat[7:0] = dout_ff;
		end else if (adr == `RELAY_ADR) begin
			nxt_rdat[3:0] = relay_ff;
		end else if (adr == `DIN_ADR) begin
			nxt_rdat[15:0] = din_flt;
		end else if (adr == `PIN_IN_ADR) begin
			nxt_rdat[3:0] = pin_flt;
		end else if (adr == `STATUS_ADR) begin
			nxt_rdat[2:0] = {ctrl_ff[`CTRL_MIRROR], ctrl_ff[`CTRL_ARM], safe};
		end else if (adr >= `TEMP_ADR && adr < `TEMP_ADR + 10'h010) begin
			nxt_rdat[15:0] = temp_ff[adr[3:2]];
		end else if (adr >= `HUM_ADR && adr < `HUM_ADR + 10'h010) begin
			nxt_rdat[15:0] = hum_ff[adr[3:2]];
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ack_ff  <= 1'b0;
			rdat_ff <= 32'h0000_0000;
		end else begin
			ack_ff  <= take;
			rdat_ff <= take ? nxt_rdat : 32'h0000_0000;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign wb_rsp_o.ack    = ack_ff;
	assign wb_rsp_o.dat    = rdat_ff;
	assign dout_o          = dout_q_ff;
	assign relay_o         = relay_q_ff;
	assign pwm_hiz_o       = hiz_ff;
	assign pin_o           = pin_o_ff;
	assign pin_oe_o        = pin_oe_ff;
	assign pin_pullup_o    = pullup_ff;
	assign probe_mode_o    = probe_ff;
	assign persist_store_o = store_ff;
	assign status_lamp_o   = lamp_ff;

endmodule

/* File: shared/io_cfg_map.svh */
// Purpose: Addresses, field positions, reset values and timing of the I/O configuration bank.
// Assumes: Byte addresses on a 10-bit Wishbone address, one register per aligned word.
// Notes:   Definitions only.
`ifndef IO_CFG_MAP_SVH
`define IO_CFG_MAP_SVH

// ---------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------
`define CTRL_ADR       10'h000
`define IN_FILT_ADR    10'h004
`define PIN_CFG_ADR    10'h024
`define PIN_FILT_ADR   10'h028
`define PIN_OUT_ADR    10'h030
`define DOUT_ADR       10'h034
`define RELAY_ADR      10'h038
`define DIN_ADR        10'h03C
`define PIN_IN_ADR     10'h040
`define STATUS_ADR     10'h044
`define TEMP_ADR       10'h050
`define HUM_ADR        10'h060
`define POUT_REGION    2'h1
`define PIN_REGION     2'h2

// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define CTRL_HALT      0
`define CTRL_MIRROR    1
`define CTRL_ARM       2
`define CTRL_LAMP_OFF  3
`define CTRL_PULLUP    4
`define CTRL_MASK      8'h1F
`define CFG_RST        8'h00
`define CFG_DIR_LSB    0
`define CFG_PROBE_LSB  4

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_KHZ        25000
`define LAMP_HALF_MS   250
`define HALT_FLASHES   3'h2

`endif

/* File: shared/io_cfg_pkg.sv */
// Purpose: Types shared by the I/O configuration bank.
// Assumes: Classic Wishbone with 32-bit data and 10-bit byte address.
// Notes:   Constants live in io_cfg_map.svh.
package io_cfg_pkg;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [9:0]  adr;
		logic [31:0] dat;
		logic [3:0]  sel;
	} wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} wb_rsp_t;

	typedef struct packed {
		logic [15:0] temp;
		logic [15:0] hum;
	} probe_word_t;

	typedef enum logic {
		ST_RUN,
		ST_SAFE
	} mode_t;

endpackage

/* File: verilog/level_filter.sv */
// Purpose: Debounce of one input, counted in exchange cycles.
// Assumes: level_i is already synchronised; tick_i marks one exchange.
// Notes:   A count of zero passes the sample on every tick.
`timescale 1ns/1ns
module level_filter #(
	parameter int CNT_W = 8
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             resetn_i,
	// Sample and setting
	input  wire logic             tick_i,
	input  wire logic             level_i,
	input  wire logic [CNT_W-1:0] count_i,
	// Filtered level
	output logic                  level_o
);

	generate
		if (CNT_W < 1) begin : g_bad_width
			$error("level_filter needs CNT_W of at least one");
		end
	endgenerate

	logic [CNT_W-1:0] run_ff;
	logic [CNT_W-1:0] nxt_run;
	logic             cand_ff;
	logic             level_ff;

	// A sample that differs from the candidate starts the run again at one.
	always_comb begin
		if (level_i != cand_ff) begin
			nxt_run = {{(CNT_W-1){1'b0}}, 1'b1};
		end else if (run_ff == {CNT_W{1'b1}}) begin
			nxt_run = run_ff;
		end else begin
			nxt_run = run_ff + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			run_ff   <= '0;
			cand_ff  <= 1'b0;
			level_ff <= 1'b0;
		end else if (tick_i) begin
			run_ff  <= nxt_run;
			cand_ff <= level_i;
			if (count_i == '0 || nxt_run >= count_i) begin
				level_ff <= level_i;
			end
		end
	end

	assign level_o = level_ff;

endmodule

/* File: bench/io_cfg_props.sv */
// Purpose: Port assertions for the I/O configuration bank.
// Assumes: LAMP_HALF_CYC is 4, so a flash frame is 32 cycles.
// Notes:   Bound to the design after the module.
`timescale 1ns/1ns
`include "io_cfg_map.svh"
module io_cfg_props #(
	parameter int PIN_N = 4
) (
	// Clock and reset
	input wire logic                clk_i,
	input wire logic                resetn_i,
	// Bus
	input wire io_cfg_pkg::wb_req_t wb_req_i,
	input wire io_cfg_pkg::wb_rsp_t wb_rsp_o,
	// Outputs
	input wire logic [7:0]          dout_o,
	input wire logic [3:0]          relay_o,
	input wire logic                pwm_hiz_o,
	input wire logic [PIN_N-1:0]    pin_o,
	input wire logic [PIN_N-1:0]    pin_oe_o,
	input wire logic [PIN_N-1:0]    pin_pullup_o,
	input wire logic [PIN_N-1:0]    probe_mode_o,
	input wire logic                persist_store_o,
	input wire logic                status_lamp_o
);
	// ---------------------------------------------------------------
	// Shadow of the control byte
	// ---------------------------------------------------------------
	logic safe_ff;
	logic lamp_off_ff;
	wire take = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
	wire ctrl_wr = take && wb_req_i.we && wb_req_i.sel[0] && wb_req_i.adr == `CTRL_ADR && !safe_ff;
	wire halt_wr = ctrl_wr && wb_req_i.dat[`CTRL_HALT];
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i)
			safe_ff <= 1'b0;
		else if (halt_wr)
			safe_ff <= 1'b1;
	end
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i)
			lamp_off_ff <= 1'b0;
		else if (ctrl_wr)
			lamp_off_ff <= wb_req_i.dat[`CTRL_LAMP_OFF];
	end
	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);
	a_ack_follows: assert property (take |=> wb_rsp_o.ack)
		else $error("ack missing after request");
	a_ack_single: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
		else $error("ack longer than one cycle");
	a_dat_idle: assert property (!wb_rsp_o.ack |-> wb_rsp_o.dat == 32'h0)
		else $error("read data outside ack");
	a_safe_outputs: assert property (
		safe_ff |=> dout_o == 8'h00 && relay_o == 4'h0 && pwm_hiz_o)
		else $error("outputs live in safe state");
	a_safe_frozen: assert property (
		safe_ff ##1 safe_ff |=> $stable({pin_o, pin_oe_o, pin_pullup_o, probe_mode_o}))
		else $error("pins changed in safe state");
	a_store_arm: assert property (
		halt_wr |=> persist_store_o == $past(wb_req_i.dat[`CTRL_ARM]))
		else $error("store pulse does not follow arm bit");
	a_store_entry: assert property (
		persist_store_o |-> safe_ff ##1 !persist_store_o)
		else $error("store pulse outside safe entry");
	a_lamp_run: assert property (
		!safe_ff && !$past(safe_ff) && lamp_off_ff == $past(lamp_off_ff) |-> status_lamp_o != lamp_off_ff)
		else $error("lamp wrong in run state");
	a_lamp_flash: assert property (
		safe_ff && !lamp_off_ff && status_lamp_o |-> ##[1:8] !status_lamp_o)
		else $error("lamp does not flash");
	a_lamp_dark: assert property (
		safe_ff && !lamp_off_ff && !status_lamp_o |-> ##[1:24] status_lamp_o)
		else $error("lamp stays dark");
	a_pullup_cond: assert property (
		|pin_pullup_o |-> (pin_pullup_o & (pin_oe_o | ~pin_o)) == '0)
		else $error("pull-up on a driven or low pin");
	a_probe_oe: assert property (
		|probe_mode_o |-> (probe_mode_o & pin_oe_o) == '0)
		else $error("probe pin driven");
endmodule
bind io_control_config_bytes io_cfg_props #(.PIN_N(PIN_N)) io_cfg_props_i (.clk_i(clk_i), .resetn_i(resetn_i),
	.wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .dout_o(dout_o), .relay_o(relay_o), .pwm_hiz_o(pwm_hiz_o),
	.pin_o(pin_o), .pin_oe_o(pin_oe_o), .pin_pullup_o(pin_pullup_o), .probe_mode_o(probe_mode_o),
	.persist_store_o(persist_store_o), .status_lamp_o(status_lamp_o));

/* File: bench/host_xchg_model.sv */
// Purpose: Host side of the cyclic exchange and the probe readings.
// Assumes: One exchange is a one-cycle pulse.
// Notes:   Cycle time never changes, so filter counts stay valid.
`timescale 1ns/1ns
module host_xchg_model (
	// Clock
	input wire logic               clk_i,
	// Exchange and probes
	output logic                   exchange_o,
	output io_cfg_pkg::probe_word_t probe_o [4]
);
	initial exchange_o = 1'b0;
	// Fixed readings, so each pin's words are told apart by index.
	always_comb begin
		for (int k = 0; k < 4; k++)
			probe_o[k] = {8'h70, 8'(k), 8'h40, 8'(k)};
	end
	// The spacing is fixed per run; counts are set once for it.
	task xchg(input int n);
		repeat (n) begin
			@(posedge clk_i);
			exchange_o <= 1'b1;
			@(posedge clk_i);
			exchange_o <= 1'b0;
		end
	endtask
endmodule

/* File: bench/io_control_config_bytes_tb_top.sv */
// Purpose: Self-checking bench of the I/O configuration bank.
// Assumes: Persistence is armed once only, at safe entry.
// Notes:   Lamp half period shortened to 4 cycles.
`timescale 1ns/1ns
`include "io_cfg_map.svh"
module io_control_config_bytes_tb_top;
	logic                    clk_i;
	logic                    resetn_i;
	io_cfg_pkg::wb_req_t     wb_req;
	io_cfg_pkg::wb_rsp_t     wb_rsp;
	io_cfg_pkg::probe_word_t probe [4];
	logic                    exchange;
	logic [15:0]             din;
	logic [7:0]              dout;
	logic [3:0]              relay;
	logic [3:0]              pin_in;
	logic [3:0]              pin_out;
	logic [3:0]              pin_oe;
	logic [3:0]              pin_pu;
	logic [3:0]              probe_md;
	logic                    pwm_hiz;
	logic                    store;
	logic                    lamp;
	logic [31:0]             q;
	int                      err_total;
	int                      checked;
	int                      cycles;
	io_control_config_bytes #(.LAMP_HALF_CYC(4)) io_control_config_bytes_i (.clk_i(clk_i),
		.resetn_i(resetn_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp), .exchange_i(exchange), .din_i(din),
		.dout_o(dout), .relay_o(relay), .pwm_hiz_o(pwm_hiz), .pin_i(pin_in), .pin_o(pin_out),
		.pin_oe_o(pin_oe), .pin_pullup_o(pin_pu), .probe_mode_o(probe_md), .probe_i(probe),
		.persist_store_o(store), .status_lamp_o(lamp));
	host_xchg_model host_xchg_model_i (.clk_i(clk_i), .exchange_o(exchange), .probe_o(probe));
	// ---------------------------------------------------------------
	// Common tasks
	// ---------------------------------------------------------------
	task final_report;
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Waits for ack however long it takes; only the cycle ceiling ends a hang.
	task bus(input logic w, input logic [9:0] a, input logic [7:0] d);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, dat: {24'h0, d}, sel: 4'hF};
		do begin
			@(posedge clk_i);
		end while (wb_rsp.ack !== 1'b1);
		q = wb_rsp.dat;
		wb_req <= '0;
		@(posedge clk_i);
	endtask
	task rd(input logic [9:0] a, input logic [31:0] exp);
		bus(1'b0, a, 8'h00);
		check(q, exp);
	endtask
	// Inputs pass two flops before the exchange may see them.
	task settle_x(input int n);
		repeat (3) @(posedge clk_i);
		host_xchg_model_i.xchg(n);
	endtask
	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task s_reset;
		for (int k = 0; k < 8; k++)
			rd(`IN_FILT_ADR + 10'(4 * k), 32'h0);
		rd(`CTRL_ADR, 32'h0);
		rd(`PIN_CFG_ADR, 32'h0);
		rd(`PIN_FILT_ADR + 10'h4, 32'h0);
		rd(10'h3FC, 32'h0);
		check(lamp, 1'b1);
	endtask
	task s_ctrl;
		bus(1'b1, `CTRL_ADR, 8'hE8);
		rd(`CTRL_ADR, 32'h08);
		check(lamp, 1'b0);
		bus(1'b1, `CTRL_ADR, 8'h00);
		check(lamp, 1'b1);
	endtask
	task s_filter;
		din <= 16'h0001;
		settle_x(1);
		rd(`DIN_ADR, 32'h0001);
		bus(1'b1, `IN_FILT_ADR, 8'h03);
		din <= 16'h0002;
		settle_x(2);
		rd(`DIN_ADR, 32'h0001);
		din <= 16'h0003;
		settle_x(1);
		rd(`DIN_ADR, 32'h0003);
		din <= 16'h0002;
		settle_x(2);
		din <= 16'h0003;
		settle_x(1);
		din <= 16'h0002;
		settle_x(2);
		rd(`DIN_ADR, 32'h0003);
		settle_x(1);
		rd(`DIN_ADR, 32'h0002);
	endtask
	task s_pins;
		bus(1'b1, `PIN_OUT_ADR, 8'h0F);
		bus(1'b1, `CTRL_ADR, 8'h10);
		bus(1'b1, `PIN_CFG_ADR, 8'h21);
		check(pin_oe, 4'h1);
		check(pin_out, 4'hF);
		check(probe_md, 4'h2);
		check(pin_pu & 4'hD, 4'hC);
		pin_in <= 4'h4;
		settle_x(1);
		rd(`TEMP_ADR + 10'h4, 32'h7001);
		rd(`HUM_ADR + 10'h4, 32'h4001);
		rd(`TEMP_ADR, 32'h0);
		bus(1'b0, `PIN_IN_ADR, 8'h00);
		check(q & 32'hC, 32'h4);
		bus(1'b1, `PIN_FILT_ADR + 10'h4, 8'h02);
		pin_in <= 4'h8;
		settle_x(1);
		bus(1'b0, `PIN_IN_ADR, 8'h00);
		check(q & 32'hC, 32'h4);
		settle_x(1);
		bus(1'b0, `PIN_IN_ADR, 8'h00);
		check(q & 32'hC, 32'h8);
		bus(1'b1, `CTRL_ADR, 8'h00);
		check(pin_pu, 4'h0);
	endtask
	task s_persist;
		bus(1'b1, 10'h1FC, 8'hA5);
		bus(1'b1, `CTRL_ADR, 8'h02);
		host_xchg_model_i.xchg(2);
		bus(1'b1, 10'h1FC, 8'h3C);
		host_xchg_model_i.xchg(1);
		rd(10'h2FC, 32'hA5);
		host_xchg_model_i.xchg(1);
		rd(10'h2FC, 32'h3C);
		bus(1'b1, `CTRL_ADR, 8'h00);
		rd(10'h2FC, 32'h0);
	endtask
	task s_safe;
		int k;
		bus(1'b1, `DOUT_ADR, 8'hFF);
		bus(1'b1, `RELAY_ADR, 8'h0F);
		check({relay, dout}, 12'hFFF);
		bus(1'b1, `CTRL_ADR, 8'h05);
		check({pwm_hiz, relay, dout}, 13'h1000);
		rd(`STATUS_ADR, 32'h3);
		bus(1'b1, `DOUT_ADR, 8'h55);
		bus(1'b1, `CTRL_ADR, 8'h02);
		check(dout, 8'h00);
		rd(`STATUS_ADR, 32'h3);
		rd(10'h2FC, 32'h3C);
		din <= 16'hFFFF;
		settle_x(1);
		rd(`DIN_ADR, 32'h0002);
		k = 0;
		repeat (40) begin
			@(posedge clk_i);
			if (lamp === 1'b0)
				k++;
		end
		check(32'(k != 0), 32'h1);
	endtask
	// ---------------------------------------------------------------
	// Clock, reset, sequence and timeout
	// ---------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cycles++;
		if (cycles > 5000) begin
			err_total++;
			final_report;
		end
	end
	initial begin
		wb_req = '0;
		din = '0;
		pin_in = '0;
		resetn_i = 1'b0;
		repeat (10) @(posedge clk_i);
		resetn_i <= 1'b1;
		@(posedge clk_i);
		s_reset;
		s_ctrl;
		s_filter;
		s_pins;
		s_persist;
		s_safe;
		final_report;
	end
endmodule
